// File: logic/pbr_pmbus_top.sv
// management bus slave for revision, discharge control and address override
// How it works
// - the revision byte always shows 0011 in its upper nibble.
// - the revision byte always shows 0011 in its lower nibble.
// - with the discharge enable set, the output is discharged while turned off by pin or command.
// - with the override enable set, the device answers at the programmed seven-bit address.
// - with the override enable clear, the device answers at the strapped address.
// - the address override register is zero after reset, so the strap is used first.
`timescale 1ns/1ns
`include "pbr_defines.svh"
module pbr_pmbus_top
(
    input  wire logic               mclk,
    input  wire logic               resetn,
    input  wire logic               scl,
    input  wire logic               sda_in,
    output logic                    sda_out,
    output logic                    sda_oe,
    input  wire pbr_pkg::pbr_addr_t strap_addr,
    input  wire logic               ctrl_on,
    input  wire logic               op_on,
    output logic                    discharge
);
    import pbr_pkg::*;

    logic       rst_meta_r;
    logic       rst_n;
    logic       scl_q;
    logic       sda_q;
    logic       start;
    logic       stop;
    logic       scl_rise;
    logic       scl_fall;
    logic       byte_done;
    pbr_state_t state_r;
    pbr_state_t ret_r;
    pbr_byte_t  shift_r;
    pbr_byte_t  tx_r;
    pbr_byte_t  cmd_r;
    pbr_byte_t  wdata_r;
    logic [3:0] cnt_r;
    logic       oe_r;
    logic       wr_r;

    pbr_reg_if rif ();

    ////////////////////////////////////////////////////////////////////////
    // reset release through two flops
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            rst_meta_r <= 1'b0;
            rst_n      <= 1'b0;
        end
        else
        begin
            rst_meta_r <= 1'b1;
            rst_n      <= rst_meta_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end
        else
        begin
            scl_q <= scl;
            sda_q <= sda_in;
        end
    end

    assign start     = scl && scl_q && sda_q && !sda_in;
    assign stop      = scl && scl_q && !sda_q && sda_in;
    assign scl_rise  = scl && !scl_q;
    assign scl_fall  = !scl && scl_q;
    assign byte_done = scl_fall && (cnt_r == `PBR_BITS_PER_BYTE);

    ////////////////////////////////////////////////////////////////////////
    // byte-level slave: address, command, one data byte in or out
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_r <= PBR_IDLE;
            ret_r   <= PBR_IDLE;
            shift_r <= `PBR_ZERO_BYTE;
            tx_r    <= `PBR_ZERO_BYTE;
            cmd_r   <= `PBR_ZERO_BYTE;
            cnt_r   <= 4'h0;
            oe_r    <= 1'b0;
        end
        else if (stop)
        begin
            state_r <= PBR_IDLE;
            oe_r    <= 1'b0;
        end
        else if (start)
        begin
            state_r <= PBR_ADDR;
            cnt_r   <= 4'h0;
            oe_r    <= 1'b0;
        end
        else
        begin
            case (state_r)
                PBR_ADDR, PBR_CMD, PBR_WDATA:
                begin
                    if (scl_rise)
                    begin
                        shift_r <= {shift_r[6:0], sda_in};
                        cnt_r   <= cnt_r + `PBR_BIT_ONE;
                    end
                    else if (byte_done)
                    begin
                        cnt_r <= 4'h0;
                        if (state_r == PBR_ADDR)
                        begin
                            if (shift_r[7:1] == rif.dev_addr)
                            begin
                                oe_r    <= 1'b1;
                                ret_r   <= shift_r[0] ? PBR_READ : PBR_CMD;
                                state_r <= PBR_ACK;
                            end
                            else
                                state_r <= PBR_WAIT;
                        end
                        else if (state_r == PBR_CMD)
                        begin
                            cmd_r <= shift_r;
                            // unsupported commands are not acknowledged
                            oe_r    <= (shift_r == `PBR_CMD_REVISION) || (shift_r == `PBR_CMD_OUT_CTRL)
                                       || (shift_r == `PBR_CMD_ADDR_OVR);
                            ret_r   <= PBR_WDATA;
                            state_r <= PBR_ACK;
                        end
                        else
                        begin
                            oe_r    <= 1'b1;
                            ret_r   <= PBR_WAIT;
                            state_r <= PBR_ACK;
                        end
                    end
                end
                PBR_ACK:
                begin
                    if (scl_fall)
                    begin
                        state_r <= ret_r;
                        if (ret_r == PBR_READ)
                        begin
                            oe_r  <= !rif.rdata[7];
                            tx_r  <= {rif.rdata[6:0], 1'b0};
                            cnt_r <= `PBR_BIT_ONE;
                        end
                        else
                            oe_r <= 1'b0;
                        if (ret_r == PBR_WDATA && !oe_r)
                            state_r <= PBR_WAIT;
                    end
                end
                PBR_READ:
                begin
                    if (byte_done)
                    begin
                        oe_r    <= 1'b0;
                        state_r <= PBR_WAIT;
                    end
                    else if (scl_fall)
                    begin
                        oe_r  <= !tx_r[7];
                        tx_r  <= {tx_r[6:0], 1'b0};
                        cnt_r <= cnt_r + `PBR_BIT_ONE;
                    end
                end
                PBR_IDLE, PBR_WAIT:
                    oe_r <= 1'b0;
                default:
                begin
                    state_r <= PBR_IDLE;
                    oe_r    <= 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // one-cycle write strobe once the data byte is complete
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_r    <= 1'b0;
            wdata_r <= `PBR_ZERO_BYTE;
        end
        else
        begin
            wr_r    <= (state_r == PBR_WDATA) && byte_done && !start && !stop;
            wdata_r <= shift_r;
        end
    end

    assign rif.wr       = wr_r;
    assign rif.cmd      = cmd_r;
    assign rif.wdata    = wdata_r;
    assign rif.bus_stop = stop;
    assign sda_out      = 1'b0;
    assign sda_oe       = oe_r;

    pbr_regbank u_bank
    (
        .mclk       (mclk),
        .rst_n      (rst_n),
        .strap_addr (strap_addr),
        .ctrl_on    (ctrl_on),
        .op_on      (op_on),
        .discharge  (discharge),
        .rif        (rif)
    );

    ////////////////////////////////////////////////////////////////////////
    chk_ack_match: assert property (@(posedge mclk) disable iff (!rst_n)
        state_r == PBR_ADDR && byte_done && !start && !stop && shift_r[7:1] == rif.dev_addr
        |=> state_r == PBR_ACK && sda_oe)
        else $error("own address not acknowledged");
    chk_no_foreign: assert property (@(posedge mclk) disable iff (!rst_n)
        state_r == PBR_ADDR && byte_done && !start && !stop && shift_r[7:1] != rif.dev_addr
        |=> state_r == PBR_WAIT && !sda_oe)
        else $error("foreign address acknowledged");
    chk_write_strobe: assert property (@(posedge mclk) disable iff (!rst_n)
        wr_r |-> ##[1:1000] stop)
        else $error("write not followed by a stop");

    cov_write_ovr: cover property (@(posedge mclk) disable iff (!rst_n)
        wr_r && cmd_r == `PBR_CMD_ADDR_OVR);
    cov_read_rev: cover property (@(posedge mclk) disable iff (!rst_n)
        state_r == PBR_READ && cmd_r == `PBR_CMD_REVISION && byte_done);
    cov_discharge: cover property (@(posedge mclk) disable iff (!rst_n) $rose(discharge));
endmodule

// File: logic/pbr_defines.svh
// constants for the bus-reachable revision, discharge and address registers
`ifndef PBR_DEFINES_SVH
`define PBR_DEFINES_SVH

`define PBR_CMD_REVISION   8'h98
`define PBR_CMD_OUT_CTRL   8'hD1
`define PBR_CMD_ADDR_OVR   8'hD3
`define PBR_REV_PART1      4'h3
`define PBR_REV_PART2      4'h3
`define PBR_DIS_BIT        6
`define PBR_OVR_EN_BIT     7
`define PBR_OVR_RESET      8'h00
`define PBR_CTRL_RESET     8'h00
`define PBR_CTRL_MASK      8'h40
`define PBR_BITS_PER_BYTE  4'h8
`define PBR_BIT_ONE        4'h1
`define PBR_ZERO_BYTE      8'h00
`define PBR_STRAP_RESET    7'h00

`endif

// File: logic/pbr_pkg.sv
// types shared by the serial slave and the register bank
package pbr_pkg;
    typedef logic [7:0] pbr_byte_t;
    typedef logic [6:0] pbr_addr_t;
    typedef enum logic [2:0] {
        PBR_IDLE,
        PBR_ADDR,
        PBR_CMD,
        PBR_WDATA,
        PBR_ACK,
        PBR_READ,
        PBR_WAIT
    } pbr_state_t;
endpackage

// File: logic/pbr_reg_if.sv
// link between the serial slave and the register bank
`timescale 1ns/1ns
interface pbr_reg_if;
    import pbr_pkg::*;
    logic      wr;
    pbr_byte_t cmd;
    pbr_byte_t wdata;
    pbr_byte_t rdata;
    logic      cmd_ok;
    pbr_addr_t dev_addr;
    logic      bus_stop;
    modport bus  (output wr, output cmd, output wdata, output bus_stop,
                  input rdata, input cmd_ok, input dev_addr);
    modport bank (input wr, input cmd, input wdata, input bus_stop,
                  output rdata, output cmd_ok, output dev_addr);
endinterface

// File: logic/pbr_regbank.sv
// revision, discharge control and address override registers
`timescale 1ns/1ns
`include "pbr_defines.svh"
module pbr_regbank
(
    input  wire logic             mclk,
    input  wire logic             rst_n,
    input  wire pbr_pkg::pbr_addr_t strap_addr,
    input  wire logic             ctrl_on,
    input  wire logic             op_on,
    output logic                  discharge,
    pbr_reg_if.bank               rif
);
    import pbr_pkg::*;

    pbr_byte_t ctrl_r;
    pbr_byte_t ovr_r;
    pbr_byte_t ovr_act_r;
    pbr_addr_t strap_r;
    logic      strap_done_r;
    logic      discharge_r;

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_r <= `PBR_CTRL_RESET;
            ovr_r  <= `PBR_OVR_RESET;
        end
        else if (rif.wr)
        begin
            if (rif.cmd == `PBR_CMD_OUT_CTRL)
                ctrl_r <= rif.wdata & `PBR_CTRL_MASK;
            if (rif.cmd == `PBR_CMD_ADDR_OVR)
                ovr_r <= rif.wdata;
        end
    end

    // the address in use changes only at a stop, after the write was acked
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            ovr_act_r <= `PBR_OVR_RESET;
        else if (rif.bus_stop)
            ovr_act_r <= ovr_r;
    end

    // strap caught once after reset release
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            strap_r      <= `PBR_STRAP_RESET;
            strap_done_r <= 1'b0;
        end
        else if (!strap_done_r)
        begin
            strap_r      <= strap_addr;
            strap_done_r <= 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            discharge_r <= 1'b0;
        else
            discharge_r <= ctrl_r[`PBR_DIS_BIT] && !(ctrl_on && op_on);
    end

    assign discharge    = discharge_r;
    assign rif.dev_addr = ovr_act_r[`PBR_OVR_EN_BIT] ? ovr_act_r[6:0] : strap_r;

    always_comb
    begin
        rif.cmd_ok = 1'b1;
        case (rif.cmd)
            `PBR_CMD_REVISION: rif.rdata = {`PBR_REV_PART1, `PBR_REV_PART2};
            `PBR_CMD_OUT_CTRL: rif.rdata = ctrl_r;
            `PBR_CMD_ADDR_OVR: rif.rdata = ovr_r;
            default:
            begin
                rif.rdata  = `PBR_ZERO_BYTE;
                rif.cmd_ok = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    chk_rev_upper: assert property (@(posedge mclk) disable iff (!rst_n)
        rif.cmd == `PBR_CMD_REVISION |-> rif.rdata[7:4] == 4'h3)
        else $error("revision upper nibble wrong");
    chk_rev_lower: assert property (@(posedge mclk) disable iff (!rst_n)
        rif.cmd == `PBR_CMD_REVISION |-> rif.rdata[3:0] == 4'h3)
        else $error("revision lower nibble wrong");
    chk_discharge_follows: assert property (@(posedge mclk) disable iff (!rst_n)
        ##1 discharge == $past(ctrl_r[`PBR_DIS_BIT] && !(ctrl_on && op_on)))
        else $error("discharge does not follow enable and on state");
    chk_ovr_address: assert property (@(posedge mclk) disable iff (!rst_n)
        $past(rif.bus_stop) && ovr_r[`PBR_OVR_EN_BIT] |-> rif.dev_addr == ovr_r[6:0])
        else $error("programmed address not used");
    chk_strap_address: assert property (@(posedge mclk) disable iff (!rst_n)
        $past(rif.bus_stop) && !ovr_r[`PBR_OVR_EN_BIT] |-> rif.dev_addr == strap_r)
        else $error("strap address not used");
    chk_reset_value: assert property (@(posedge mclk) disable iff (!rst_n)
        $rose(strap_done_r) |-> ovr_r == 8'h00 && ovr_act_r == 8'h00)
        else $error("override not zero after reset");
    chk_addr_commit: assert property (@(posedge mclk) disable iff (!rst_n)
        !rif.bus_stop |=> $stable(ovr_act_r))
        else $error("address changed outside a stop");
endmodule

// File: bench/pbr_host_model.sv
// management bus host model that drives the slave's clock and data lines
`timescale 1ns/1ns
module pbr_host_model
(
    input  wire logic mclk,
    output logic      scl,
    input  wire logic sda,
    output logic      sda_pull
);
    import pbr_pkg::*;
    localparam int HALF = 6;

    initial
    begin
        scl      = 1'h1;
        sda_pull = 1'h0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic wt();
        repeat (HALF) @(negedge mclk);
    endtask

    // also serves as repeated start, since data is released first
    task automatic bus_start();
        sda_pull = 1'h0;
        wt();
        scl = 1'h1;
        wt();
        sda_pull = 1'h1;
        wt();
        scl = 1'h0;
        @(negedge mclk);
    endtask

    task automatic bus_stop();
        sda_pull = 1'h1;
        wt();
        scl = 1'h1;
        wt();
        sda_pull = 1'h0;
        wt();
    endtask

    // data only moves one cycle after clock low, so it never looks like start or stop
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
        for (int i = 7; i >= 0; i--)
        begin
            sda_pull = ~tx[i];
            wt();
            scl = 1'h1;
            wt();
            rx[i] = sda;
            scl   = 1'h0;
            @(negedge mclk);
        end
        sda_pull = 1'h0;
        wt();
        scl = 1'h1;
        wt();
        ack = (sda === 1'h0);
        scl = 1'h0;
        @(negedge mclk);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic write_byte(input pbr_addr_t a, input pbr_byte_t c, input pbr_byte_t d, output logic ok);
        pbr_byte_t rx;
        logic      k0, k1, k2;
        bus_start();
        xfer({a, 1'h0}, rx, k0);
        xfer(c, rx, k1);
        xfer(d, rx, k2);
        bus_stop();
        ok = k0 & k1 & k2;
    endtask

    // command write, repeated start, one byte back, host nack
    task automatic read_byte(input pbr_addr_t a, input pbr_byte_t c, output pbr_byte_t d, output logic ok);
        pbr_byte_t rx;
        logic      k0, k1, k2, k3;
        bus_start();
        xfer({a, 1'h0}, rx, k0);
        xfer(c, rx, k1);
        bus_start();
        xfer({a, 1'h1}, rx, k2);
        xfer(8'hFF, d, k3);
        bus_stop();
        ok = k0 & k1 & k2;
    endtask
endmodule

// File: bench/pbr_pmbus_tb_top.sv
// self-checking bench for the revision, discharge and address override registers
`timescale 1ns/1ns
module pmbus_revision_address_control_tb_top;
    import pbr_pkg::*;
    localparam pbr_addr_t STRAP = 7'h2C;
    logic        mclk       = 1'h0;
    logic        resetn     = 1'h0;
    logic        ctrl_on    = 1'h1;
    logic        op_on      = 1'h1;
    pbr_addr_t   strap_addr = STRAP;
    logic        scl;
    logic        sda;
    logic        sda_pull;
    logic        sda_out;
    logic        sda_oe;
    logic        discharge;
    logic [15:0] lfsr       = 16'hCFCA;
    int          err_count  = 0;
    int          n_checks   = 0;

    always #20 mclk = ~mclk;
    // open-drain data line with pull-up
    assign sda = (sda_pull | (sda_oe & ~sda_out)) ? 1'h0 : 1'h1;

    pbr_pmbus_top uut (.mclk(mclk), .resetn(resetn), .scl(scl), .sda_in(sda), .sda_out(sda_out),
        .sda_oe(sda_oe), .strap_addr(strap_addr), .ctrl_on(ctrl_on), .op_on(op_on), .discharge(discharge));
    pbr_host_model host (.mclk(mclk), .scl(scl), .sda(sda), .sda_pull(sda_pull));

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    function automatic pbr_byte_t exp_ctrl(input pbr_byte_t d);
        return d & 8'h40;
    endfunction

    function automatic logic exp_dis(input pbr_byte_t d, input logic c, input logic o);
        return d[6] & ~(c & o);
    endfunction

    task automatic rnd(output pbr_byte_t v);
        lfsr = lfsr_next(lfsr);
        v    = lfsr[7:0];
    endtask

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        if (err_count == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial
    begin
        repeat (60000) @(posedge mclk);
        err_count++;
        report_and_stop();
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        pbr_byte_t v;
        pbr_byte_t d;
        pbr_addr_t a;
        logic      ok;
        logic      c;
        logic      o;
        repeat (4) @(posedge mclk);
        @(negedge mclk);
        resetn = 1'h1;
        repeat (8) @(negedge mclk);
        host.read_byte(STRAP, 8'hD3, d, ok);
        check("override after reset", d, 8'h00);
        host.read_byte(STRAP, 8'h98, d, ok);
        check("revision high nibble", {4'h0, d[7:4]}, 8'h03);
        check("revision low nibble", {4'h0, d[3:0]}, 8'h03);
        // the revision byte is only ever read, so another register is written before reading it again
        host.write_byte(STRAP, 8'hD1, 8'hCC, ok);
        host.read_byte(STRAP, 8'h98, d, ok);
        check("revision after write", d, 8'h33);
        host.write_byte(STRAP, 8'hD2, 8'h55, ok);
        check("unsupported command ack", {7'h00, ok}, 8'h00);
        for (int k = 0; k < 6; k++)
        begin
            rnd(v);
            if (k == 0)
                v = 8'hFF;
            if (k == 1)
                v = 8'hBF;
            host.write_byte(STRAP, 8'hD1, v, ok);
            host.read_byte(STRAP, 8'hD1, d, ok);
            check("control readback", d, exp_ctrl(v));
            for (int m = 0; m < 4; m++)
            begin
                c       = m[1];
                o       = m[0];
                ctrl_on = c;
                op_on   = o;
                repeat (3) @(negedge mclk);
                check("discharge", {7'h00, discharge}, {7'h00, exp_dis(v, c, o)});
            end
        end
        rnd(v);
        a = (v[6:0] == STRAP) ? (v[6:0] ^ 7'h01) : v[6:0];
        host.write_byte(STRAP, 8'hD3, {1'h1, a}, ok);
        check("override write ack", {7'h00, ok}, 8'h01);
        host.read_byte(a, 8'hD3, d, ok);
        check("override readback", d, {1'h1, a});
        check("ack at programmed address", {7'h00, ok}, 8'h01);
        host.read_byte(STRAP, 8'h98, d, ok);
        check("ack at strap address", {7'h00, ok}, 8'h00);
        host.write_byte(a, 8'hD3, {1'h0, a}, ok);
        check("override clear ack", {7'h00, ok}, 8'h01);
        host.read_byte(STRAP, 8'hD3, d, ok);
        check("strap readback", d, {1'h0, a});
        check("ack at strap again", {7'h00, ok}, 8'h01);
        host.read_byte(a, 8'h98, d, ok);
        check("ack at stale address", {7'h00, ok}, 8'h00);
        report_and_stop();
    end
endmodule
